// File: imb_pkg.sv
// constants, carriers and decoders shared by the internal memory bank arbiter
// assumes a single core clock domain; addresses count 32-bit lanes of a 256-bit line

package imb_pkg;

  // ****************************************************
  // geometry
  // ****************************************************
  localparam int ROW_W       = 8;
  localparam int LANE_W      = 3;
  localparam int ADDR_W      = ROW_W + LANE_W + 2;
  localparam int REGION_BIT  = ADDR_W - 1;
  localparam int PAGE_BIT    = ADDR_W - 2;
  localparam int ROW_LSB     = LANE_W;
  localparam int ROM_PAGES   = 2;
  localparam int ROM_BANKS   = 4;
  localparam int ROM_BANK_W  = 64;
  localparam int RAM_BANKS   = 8;
  localparam int RAM_BANK_W  = 32;
  localparam int LINE_W      = 256;
  localparam int NBANK       = ROM_PAGES * ROM_BANKS + RAM_BANKS;
  localparam int RAM_BASE    = ROM_PAGES * ROM_BANKS;
  localparam int NREQ        = 4;
  localparam int MAX_GRANTS  = 3;

  // ****************************************************
  // requester slots, fixed priority: lowest index wins
  // ****************************************************
  localparam int SLOT_CPU0   = 0;
  localparam int SLOT_CPU1   = 1;
  localparam int SLOT_FILL   = 2;
  localparam int SLOT_PERIPH = 3;

  // ****************************************************
  // access sizes
  // ****************************************************
  localparam logic [1:0] SZ32  = 2'h0;
  localparam logic [1:0] SZ64  = 2'h1;
  localparam logic [1:0] SZ256 = 2'h2;

  typedef struct packed {
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } imb_req_t;

  // banks touched by an access: rom page0 [3:0], page1 [7:4], ram [15:8]
  function automatic logic [NBANK-1:0] imb_bank_mask(input logic [ADDR_W-1:0] a,
                                                     input logic [1:0]        sz);
    logic [NBANK-1:0] m;
    logic [2:0]       ln;
    m  = '0;
    ln = a[LANE_W-1:0];
    if (a[REGION_BIT]) begin
      if (sz == SZ256)     m[RAM_BASE +: RAM_BANKS] = '1;
      else if (sz == SZ64) m[RAM_BASE + {ln[2:1], 1'b0} +: 2] = 2'h3;
      else                 m[RAM_BASE + ln] = 1'b1;
    end else begin
      if (sz == SZ256) m[a[PAGE_BIT]*ROM_BANKS +: ROM_BANKS] = '1;
      else             m[a[PAGE_BIT]*ROM_BANKS + ln[2:1]] = 1'b1;
    end
    return m;
  endfunction : imb_bank_mask

  // fixed rom image pattern, one 64-bit word per page, bank and row
  function automatic logic [ROM_BANK_W-1:0] imb_rom_word(input logic             page,
                                                         input logic [1:0]       bank,
                                                         input logic [ROW_W-1:0] row);
    return {53'h0, page, bank, row} ^ 64'hA5A5_5A5A_0F0F_F0F0;
  endfunction : imb_rom_word

endpackage : imb_pkg

// File: imb_arbiter.sv
// internal memory bank arbiter: rom and ram banks shared by four requesters
// assumes requests are synchronous to CLK and hold until acknowledged
//
// Behaviour
// RQ1 - The rom is two pages of 256 bits, each split into four independent 64-bit banks.
// RQ2 - The ram is one page of 256 bits, split into eight independent 32-bit banks.
// RQ3 - Up to three of the four requesters are served in one cycle when no bank collides.
// RQ4 - The core has two separate data ports of up to 64 bits each.
// RQ5 - The program cache port returns a whole 256-bit line in one access.
// RQ6 - One 32-bit port is shared by the data movement engine and external host port, one at a time.
// RQ7 - A line fill collides only with data accesses to the same page.
// RQ8 - Data accesses to other pages, or other banks of one page, all go in the same cycle; the shared port waits if three grants are already given.
// RQ9 - Colliding requesters are resolved by fixed priority and the losers stall.
// RQ10 - Writes aimed at rom complete but leave the stored contents unchanged.

`timescale 1ns/1ps
`default_nettype none

module imb_arbiter #(
  parameter int RAM_ROWS = 256
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire imb_pkg::imb_req_t    CPU0_REQ,
  input  wire logic [63:0]          CPU0_WDATA,
  output logic                      CPU0_ACK,
  output logic      [63:0]          CPU0_RDATA,
  output logic                      CPU0_RVALID,
  input  wire imb_pkg::imb_req_t    CPU1_REQ,
  input  wire logic [63:0]          CPU1_WDATA,
  output logic                      CPU1_ACK,
  output logic      [63:0]          CPU1_RDATA,
  output logic                      CPU1_RVALID,
  input  wire imb_pkg::imb_req_t    FILL_REQ,
  output logic                      FILL_ACK,
  output logic      [255:0]         FILL_RDATA,
  output logic                      FILL_RVALID,
  input  wire imb_pkg::imb_req_t    DMA_REQ,
  input  wire logic [31:0]          DMA_WDATA,
  output logic                      DMA_ACK,
  output logic                      DMA_RVALID,
  input  wire imb_pkg::imb_req_t    HOST_REQ,
  input  wire logic [31:0]          HOST_WDATA,
  output logic                      HOST_ACK,
  output logic                      HOST_RVALID,
  output logic      [31:0]          PERIPH_RDATA
);

  // ****************************************************
  // requester view
  // ****************************************************
  imb_pkg::imb_req_t          r     [imb_pkg::NREQ];
  logic [1:0]                 sz    [imb_pkg::NREQ];
  logic [63:0]                wd    [imb_pkg::NREQ];
  logic [imb_pkg::NBANK-1:0]  mask  [imb_pkg::NREQ];
  logic [imb_pkg::NREQ-1:0]   grant;
  logic                       per_host;

  // engine wins the shared port over the host port
  assign per_host = !DMA_REQ.req; // RQ6

  always_comb begin
    r[imb_pkg::SLOT_CPU0]    = CPU0_REQ;
    r[imb_pkg::SLOT_CPU1]    = CPU1_REQ;
    r[imb_pkg::SLOT_FILL]    = FILL_REQ;
    r[imb_pkg::SLOT_FILL].wr = 1'b0;
    r[imb_pkg::SLOT_PERIPH]  = per_host ? HOST_REQ : DMA_REQ; // RQ6
    sz[imb_pkg::SLOT_CPU0]   = imb_pkg::SZ64; // RQ4
    sz[imb_pkg::SLOT_CPU1]   = imb_pkg::SZ64; // RQ4
    sz[imb_pkg::SLOT_FILL]   = imb_pkg::SZ256; // RQ5
    sz[imb_pkg::SLOT_PERIPH] = imb_pkg::SZ32;
    wd[imb_pkg::SLOT_CPU0]   = CPU0_WDATA;
    wd[imb_pkg::SLOT_CPU1]   = CPU1_WDATA;
    wd[imb_pkg::SLOT_FILL]   = '0;
    wd[imb_pkg::SLOT_PERIPH] = {32'h0, per_host ? HOST_WDATA : DMA_WDATA};
  end

  // ****************************************************
  // bank decode and grant
  // ****************************************************
  genvar gi;
  generate
    for (gi = 0; gi < imb_pkg::NREQ; gi++) begin : g_mask
      // a fill claims its whole page, so it meets only same-page accesses
      assign mask[gi] = imb_pkg::imb_bank_mask(r[gi].addr, sz[gi]); // RQ7
    end
  endgenerate

  always_comb begin
    logic [imb_pkg::NBANK-1:0] used;
    int                        cnt;
    used  = '0;
    cnt   = 0;
    grant = '0;
    for (int i = 0; i < imb_pkg::NREQ; i++) begin
      if (r[i].req && cnt < imb_pkg::MAX_GRANTS && (mask[i] & used) == '0) begin // RQ3 RQ8 RQ9
        grant[i] = 1'b1;
        used     = used | mask[i];
        cnt      = cnt + 1;
      end
    end
  end

  assign CPU0_ACK = grant[imb_pkg::SLOT_CPU0];
  assign CPU1_ACK = grant[imb_pkg::SLOT_CPU1];
  assign FILL_ACK = grant[imb_pkg::SLOT_FILL];
  assign DMA_ACK  = grant[imb_pkg::SLOT_PERIPH] && !per_host; // RQ6
  assign HOST_ACK = grant[imb_pkg::SLOT_PERIPH] && per_host; // RQ6

  // ****************************************************
  // ram banks
  // ****************************************************
  logic [imb_pkg::RAM_BANK_W-1:0] ram [imb_pkg::RAM_BANKS][RAM_ROWS];

  generate
    for (gi = 0; gi < imb_pkg::RAM_BANKS; gi++) begin : g_ram
      logic                           we;
      logic [imb_pkg::ROW_W-1:0]      wrow;
      logic [imb_pkg::RAM_BANK_W-1:0] wdat;
      always_comb begin
        we   = 1'b0;
        wrow = '0;
        wdat = '0;
        for (int i = 0; i < imb_pkg::NREQ; i++) begin
          // rom writes never reach a bank here
          if (grant[i] && r[i].wr && r[i].addr[imb_pkg::REGION_BIT] &&
              mask[i][imb_pkg::RAM_BASE + gi]) begin // RQ2 RQ10
            we   = 1'b1;
            wrow = r[i].addr[imb_pkg::ROW_LSB +: imb_pkg::ROW_W];
            wdat = (sz[i] == imb_pkg::SZ64 && gi % 2 == 1) ? wd[i][63:32] : wd[i][31:0];
          end
        end
      end
      always_ff @(posedge CLK) begin
        if (we) begin
          ram[gi][wrow] <= wdat;
        end
      end
    end
  endgenerate

  // ****************************************************
  // line assembly and read return
  // ****************************************************
  logic [imb_pkg::LINE_W-1:0] line [imb_pkg::NREQ];
  logic [imb_pkg::LINE_W-1:0] pick [imb_pkg::NREQ];

  always_comb begin
    for (int i = 0; i < imb_pkg::NREQ; i++) begin
      logic [imb_pkg::ROW_W-1:0] row;
      logic [2:0]                ln;
      row     = r[i].addr[imb_pkg::ROW_LSB +: imb_pkg::ROW_W];
      ln      = r[i].addr[imb_pkg::LANE_W-1:0];
      line[i] = '0;
      for (int b = 0; b < imb_pkg::RAM_BANKS; b++) begin
        if (r[i].addr[imb_pkg::REGION_BIT]) begin
          line[i][b*imb_pkg::RAM_BANK_W +: imb_pkg::RAM_BANK_W] = ram[b][row]; // RQ2
        end
      end
      for (int b = 0; b < imb_pkg::ROM_BANKS; b++) begin
        if (!r[i].addr[imb_pkg::REGION_BIT]) begin
          line[i][b*imb_pkg::ROM_BANK_W +: imb_pkg::ROM_BANK_W] =
            imb_pkg::imb_rom_word(r[i].addr[imb_pkg::PAGE_BIT], 2'(b), row); // RQ1
        end
      end
      if (sz[i] == imb_pkg::SZ256)     pick[i] = line[i];
      else if (sz[i] == imb_pkg::SZ64) pick[i] = {192'h0, line[i][ln[2:1]*64 +: 64]};
      else                             pick[i] = {224'h0, line[i][ln*32 +: 32]};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CPU0_RDATA   <= '0;
      CPU1_RDATA   <= '0;
      FILL_RDATA   <= '0;
      PERIPH_RDATA <= '0;
    end else begin
      if (grant[imb_pkg::SLOT_CPU0] && !CPU0_REQ.wr) CPU0_RDATA <= pick[imb_pkg::SLOT_CPU0][63:0];
      if (grant[imb_pkg::SLOT_CPU1] && !CPU1_REQ.wr) CPU1_RDATA <= pick[imb_pkg::SLOT_CPU1][63:0];
      if (grant[imb_pkg::SLOT_FILL]) FILL_RDATA <= pick[imb_pkg::SLOT_FILL]; // RQ5
      if (grant[imb_pkg::SLOT_PERIPH] && !r[imb_pkg::SLOT_PERIPH].wr) begin
        PERIPH_RDATA <= pick[imb_pkg::SLOT_PERIPH][31:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CPU0_RVALID <= 1'b0;
      CPU1_RVALID <= 1'b0;
      FILL_RVALID <= 1'b0;
      DMA_RVALID  <= 1'b0;
      HOST_RVALID <= 1'b0;
    end else begin
      CPU0_RVALID <= CPU0_ACK && !CPU0_REQ.wr; // RQ4
      CPU1_RVALID <= CPU1_ACK && !CPU1_REQ.wr; // RQ4
      FILL_RVALID <= FILL_ACK; // RQ5
      DMA_RVALID  <= DMA_ACK && !DMA_REQ.wr;
      HOST_RVALID <= HOST_ACK && !HOST_REQ.wr;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  logic [63:0] exp_rom0;
  assign exp_rom0 = imb_pkg::imb_rom_word(CPU0_REQ.addr[imb_pkg::PAGE_BIT],
                                          CPU0_REQ.addr[2:1],
                                          CPU0_REQ.addr[imb_pkg::ROW_LSB +: imb_pkg::ROW_W]);

  chk_grant_limit: assert property (@(posedge CLK) disable iff (RST) // RQ3
    $countones(grant) <= 3) else $error("more than three grants");

  chk_bank_disjoint: assert property (@(posedge CLK) disable iff (RST) // RQ8
    !(CPU0_ACK && CPU1_ACK && (mask[0] & mask[1]) != '0)) else $error("bank granted twice");

  chk_cpu1_nostall: assert property (@(posedge CLK) disable iff (RST) // RQ8
    CPU1_REQ.req && !(CPU0_REQ.req && (mask[0] & mask[1]) != '0) |-> CPU1_ACK)
    else $error("cpu1 stalled without conflict");

  chk_fill_page: assert property (@(posedge CLK) disable iff (RST) // RQ7
    FILL_REQ.req && ((mask[2] & ((CPU0_ACK ? mask[0] : '0) | (CPU1_ACK ? mask[1] : '0))) == '0)
    |-> FILL_ACK) else $error("fill stalled by other page");

  chk_cpu0_first: assert property (@(posedge CLK) disable iff (RST) // RQ9
    CPU0_REQ.req |-> CPU0_ACK) else $error("top priority port stalled");

  chk_shared_port: assert property (@(posedge CLK) disable iff (RST) // RQ6
    DMA_REQ.req && HOST_REQ.req |-> !HOST_ACK) else $error("host served over engine");

  chk_read_return: assert property (@(posedge CLK) disable iff (RST) // RQ4
    CPU0_ACK && !CPU0_REQ.wr |=> CPU0_RVALID ##1 (!CPU0_RVALID || $past(CPU0_ACK)))
    else $error("cpu0 read return wrong");

  chk_fill_line: assert property (@(posedge CLK) disable iff (RST) // RQ5
    FILL_ACK |=> FILL_RVALID && FILL_RDATA == $past(line[2])) else $error("fill line wrong");

  chk_rom_fixed: assert property (@(posedge CLK) disable iff (RST) // RQ10
    CPU0_ACK && !CPU0_REQ.addr[imb_pkg::REGION_BIT] && !CPU0_REQ.wr
    |=> CPU0_RDATA == $past(exp_rom0)) else $error("rom contents changed");

endmodule : imb_arbiter

`default_nettype wire

// File: imb_requester.sv
// requester model for one port of the bank arbiter
// assumes NEW is pulsed for one cycle by the bench while the port is idle

`timescale 1ns/1ps
`default_nettype none

module imb_requester (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire imb_pkg::imb_req_t NEW,
  input  wire logic              ACK,
  output var  imb_pkg::imb_req_t REQ
);
  // ****************************************************
  // hold until acknowledged, then scramble the released lines
  // ****************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REQ <= '0;
    end else if (NEW.req) begin
      REQ <= NEW;
    end else if (REQ.req && ACK) begin
      REQ <= '{req: 1'b0, wr: ~REQ.wr, addr: ~REQ.addr};
    end
  end
endmodule : imb_requester

`default_nettype wire

// File: internal_memory_bank_arbiter_tb_top.sv
// self-checking bench for the internal memory bank arbiter
// assumes imb_pkg, imb_arbiter and imb_requester are compiled first

`timescale 1ns/1ps
`default_nettype none

module internal_memory_bank_arbiter_tb_top;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  imb_pkg::imb_req_t [4:0] nreq = '0;
  imb_pkg::imb_req_t [4:0] pend = '0;
  imb_pkg::imb_req_t [4:0] rq;
  logic [4:0]              ack;
  logic [4:0]              rv;
  logic [63:0]             w0 = '0;
  logic [63:0]             w1 = '0;
  logic [31:0]             wd = '0;
  logic [31:0]             wh = '0;
  logic [63:0]             rd0;
  logic [63:0]             rd1;
  logic [255:0]            rdf;
  logic [31:0]             rdp;
  int                      bad_count = 0;
  int                      compares = 0;
  // ****************************************************
  // rows: cpu0, cpu1, fill, dma addresses; grants {dma,fill,cpu1,cpu0}
  // ****************************************************
  logic [12:0] ra [5][4] = '{'{13'h0008, 13'h000A, 13'h0808, 13'h1008},
                             '{13'h0008, 13'h0008, 13'h0008, 13'h1008},
                             '{13'h1008, 13'h100A, 13'h0008, 13'h100C},
                             '{13'h1008, 13'h1009, 13'h1808, 13'h100C},
                             '{13'h0808, 13'h0008, 13'h0008, 13'h1008}};
  logic [3:0]  rx [5] = '{4'h7, 4'h9, 4'h7, 4'h9, 4'hB};

  always #50 clk = ~clk;

  for (genvar k = 0; k < 5; k++) begin : g_rqm
    imb_requester rqm (.CLK(clk), .RST(rst), .NEW(nreq[k]), .ACK(ack[k]), .REQ(rq[k]));
  end

  imb_arbiter uut (.CLK(clk), .RST(rst),
    .CPU0_REQ(rq[0]), .CPU0_WDATA(w0), .CPU0_ACK(ack[0]), .CPU0_RDATA(rd0), .CPU0_RVALID(rv[0]),
    .CPU1_REQ(rq[1]), .CPU1_WDATA(w1), .CPU1_ACK(ack[1]), .CPU1_RDATA(rd1), .CPU1_RVALID(rv[1]),
    .FILL_REQ(rq[2]), .FILL_ACK(ack[2]), .FILL_RDATA(rdf), .FILL_RVALID(rv[2]),
    .DMA_REQ(rq[3]), .DMA_WDATA(wd), .DMA_ACK(ack[3]), .DMA_RVALID(rv[3]),
    .HOST_REQ(rq[4]), .HOST_WDATA(wh), .HOST_ACK(ack[4]), .HOST_RVALID(rv[4]),
    .PERIPH_RDATA(rdp));

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [63:0] rom_w(input logic p, input logic [1:0] b, input logic [7:0] r);
    return {53'h0, p, b, r} ^ 64'hA5A5_5A5A_0F0F_F0F0;
  endfunction : rom_w

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic put(input int i, input logic wr, input logic [12:0] a);
    pend[i] = '{req: 1'b1, wr: wr, addr: a};
  endtask : put

  // new requests go out once per cycle, so no strobe is set twice in one time step
  task automatic step();
    nreq = pend;
    pend = '0;
    @(posedge clk);
    #1;
  endtask : step

  task automatic drain();
    int n;
    n = 0;
    while ((rq[0].req | rq[1].req | rq[2].req | rq[3].req | rq[4].req) && n < 20) begin
      step();
      n++;
    end
    if (n == 20) check(1, 0);
    step();
  endtask : drain

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #(3000 * 100);
    bad_count++;
    test_done();
  end

  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    repeat (5) @(posedge clk);
    check(rv, 5'h0);
    check(rd0, 64'h0);
    #1;
    rst = 1'b0;
    $display("reset test done");
    for (int r = 0; r < 5; r++) begin
      for (int i = 0; i < 4; i++) put(i, 1'b0, ra[r][i]);
      step();
      check(ack[3:0], rx[r]);
      drain();
      $display("row %0d done", r);
    end
    w0 = 64'h1122_3344_5566_7788;
    put(0, 1'b1, 13'h1010);
    step();
    check(ack[0], 1'b1);
    put(1, 1'b0, 13'h1010);
    put(3, 1'b0, 13'h1011);
    step();
    check(ack[3:1], 3'b001);
    step();
    check({rv[1], rd1}, {1'b1, w0});
    step();
    check({rv[3], rdp}, {1'b1, 32'h1122_3344});
    $display("ram pairing test done");
    w0 = 64'hFFFF_FFFF_FFFF_FFFF;
    put(0, 1'b1, 13'h0008);
    step();
    check(ack[0], 1'b1);
    put(0, 1'b0, 13'h0008);
    step();
    step();
    check(rd0, rom_w(1'b0, 2'h0, 8'h01));
    $display("rom write test done");
    put(2, 1'b0, 13'h1010);
    step();
    step();
    check({rv[2], rdf[63:0]}, {1'b1, 64'h1122_3344_5566_7788});
    put(2, 1'b0, 13'h0808);
    step();
    step();
    check(rdf[255:192], rom_w(1'b1, 2'h3, 8'h01));
    $display("line fill test done");
    wd = 32'hCAFE_0001;
    put(3, 1'b1, 13'h1014);
    put(4, 1'b0, 13'h1014);
    step();
    check(ack[4:3], 2'b01);
    step();
    check(ack[4], 1'b1);
    step();
    check({rv[4], rdp}, {1'b1, wd});
    $display("shared port test done");
    rst = 1'b1;
    step();
    check({rv, rd0, rdp}, '0);
    check(rdf, '0);
    rst = 1'b0;
    put(0, 1'b0, 13'h0008);
    step();
    check(ack[0], 1'b1);
    step();
    check({rv[0], rd0}, {1'b1, rom_w(1'b0, 2'h0, 8'h01)});
    $display("mid-run reset test done");
    w1 = 64'h0123_4567_89AB_CDEF;
    wh = 32'h7654_3210;
    put(1, 1'b1, 13'h1018);
    put(4, 1'b1, 13'h101C);
    step();
    check(ack[4:1], 4'h9);
    put(0, 1'b0, 13'h1018);
    put(3, 1'b0, 13'h101C);
    step();
    check(ack[3:0], 4'h9);
    step();
    check({rv[0], rd0}, {1'b1, w1});
    check({rv[3], rdp}, {1'b1, wh});
    $display("second writer test done");
    test_done();
  end
endmodule : internal_memory_bank_arbiter_tb_top

`default_nettype wire
